// ===== logic/serial_cfg.svh
// Constants for the serial port with DTR/DSR flow control.
`ifndef SERIAL_CFG_SVH
`define SERIAL_CFG_SVH
`define CLK_HZ          125000000
`define BAUD_DEFAULT    3'h5
`define FIFO_DEPTH      128
`define FIFO_AW         7
`define FULL_LEVEL      100
`define RESUME_LEVEL    80
`define STOP_BITS       2
`define CHAR_NL         8'h0a
`define CHAR_CTRLC      8'h03
`endif

// ===== logic/serial_pkg.sv
// Types shared by the serial port files.
package serial_pkg;
    typedef enum logic [1:0] {
        PAR_NONE = 2'b00,
        PAR_EVEN = 2'b01,
        PAR_ODD  = 2'b10
    } parity_t;
    typedef struct packed {
        logic [2:0] baud_sel;
        parity_t    parity;
    } line_cfg_t;
    typedef enum logic [2:0] {
        LS_IDLE  = 3'b000,
        LS_START = 3'b001,
        LS_DATA  = 3'b010,
        LS_PAR   = 3'b011,
        LS_STOP  = 3'b100
    } line_st_t;
endpackage

// ===== logic/char_fifo.sv
// Receive character memory with registered read data.
`timescale 1ns/1ps
module char_fifo #(
    parameter int DEPTH = 128,
    parameter int AW    = 7
) (
    input  wire logic         clk,      // System clock.
    input  wire logic         rst,      // Asynchronous reset.
    input  wire logic         flush,    // Drop all contents.
    input  wire logic         wr_en,    // Write strobe.
    input  wire logic [7:0]   wr_data,  // Write character.
    input  wire logic         rd_en,    // Pop strobe.
    output logic      [7:0]   rd_data,  // Head character, valid after pop cycle.
    output logic      [AW:0]  level     // Stored count.
);
    logic [7:0]  mem [DEPTH];
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] rp_reg;
    wire do_wr = wr_en && (level < (AW+1)'(DEPTH));
    wire do_rd = rd_en && (level != '0);
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wp_reg] <= wr_data;
        end
        rd_data <= mem[rp_reg];
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_reg <= '0;
            rp_reg <= '0;
            level  <= '0;
        end else if (flush) begin
            wp_reg <= '0;
            rp_reg <= '0;
            level  <= '0;
        end else begin
            wp_reg <= wp_reg + AW'(do_wr);
            rp_reg <= rp_reg + AW'(do_rd);
            level  <= level + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule

// ===== logic/serial_port.sv
// Serial port with DTR/DSR hardware flow control, data terminal side.
// Operation
// - Characters are accepted whether DTR is driven true or false.
// - DTR goes false when about one hundred characters are buffered.
// - DTR returns true once the buffer drains to eighty characters, unless a pending response has seen its newline.
// - Pending response plus received newline holds DTR false until sent.
// - DTR returns true after the last response character unless buffer full.
// - DSR is sampled before each transmitted character; false holds transmission.
// - DTR stays false while transmission is held off by DSR.
// - Ctrl-C aborts the operation and discards pending output.
// - Frames have one start bit and two stop bits, fixed.
// - Baud selectable 300 to 9600, default 9600, held across resets.
// - No parity means eight data bits; even or odd means seven.
`timescale 1ns/1ps
`include "serial_cfg.svh"
module serial_port
    import serial_pkg::*;
#(
    parameter int CLK_HZ = `CLK_HZ
) (
    input  wire logic      clk,          // System clock, 125 MHz.
    input  wire logic      rst,          // Asynchronous reset, active high.
    input  wire line_cfg_t cfg,          // Baud and parity selection, kept outside.
    input  wire logic      rxd,          // Serial receive line.
    input  wire logic      dsr,          // Data set ready, high is true.
    output logic           txd,          // Serial transmit line.
    output logic           dtr,          // Data terminal ready, high is true.
    input  wire logic      cmd_pop,      // Consume one received character.
    output logic [7:0]     cmd_data,     // Character read, valid cycle after pop.
    output logic           cmd_avail,    // Receive buffer not empty.
    input  wire logic      resp_pend,    // Query processed, response waiting.
    input  wire logic      rsp_valid,    // Response character offered.
    input  wire logic [7:0] rsp_data,    // Response character.
    input  wire logic      rsp_last,     // Last character of the response.
    output logic           rsp_ready,    // Response character taken.
    output logic           dev_clear,    // One-cycle abort pulse on Ctrl-C.
    output logic           parity_err    // Pulse on received parity mismatch.
);
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] baud_div(input logic [2:0] sel);
        int unsigned rate;
        rate = 300 << ((sel > 3'h5) ? 3'h5 : sel);
        return 16'((CLK_HZ / 16) / rate);
    endfunction

    wire [15:0] div16    = baud_div(cfg.baud_sel);
    wire        par_on   = cfg.parity != PAR_NONE;
    wire [3:0]  nbits    = par_on ? 4'h7 : 4'h8;
    wire        par_odd  = cfg.parity == PAR_ODD;

    // Sixteen-times oversampling tick shared by both directions.
    logic [15:0] tick_cnt_reg;
    logic        tick_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_cnt_reg <= 16'h0;
            tick_reg     <= 1'b0;
        end else begin
            tick_reg     <= tick_cnt_reg == 16'h0;
            tick_cnt_reg <= (tick_cnt_reg == 16'h0) ? div16 - 16'h1 : tick_cnt_reg - 16'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receiver.
    line_st_t    rst_st_reg;
    logic [3:0]  rph_reg;
    logic [3:0]  rbit_reg;
    logic [7:0]  rsh_reg;
    logic        rpar_reg;
    logic        rx_stb_reg;
    logic [7:0]  rx_chr_reg;
    logic        rx_perr_reg;
    wire         mid = tick_reg && rph_reg == 4'h7;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rst_st_reg <= LS_IDLE;
            rph_reg <= 4'h0; rbit_reg <= 4'h0; rsh_reg <= 8'h0; rpar_reg <= 1'b0;
            rx_stb_reg <= 1'b0; rx_chr_reg <= 8'h0; rx_perr_reg <= 1'b0;
        end else begin
            rx_stb_reg <= 1'b0;
            if (tick_reg) rph_reg <= rph_reg + 4'h1;
            case (rst_st_reg)
                LS_IDLE: if (!rxd) begin
                    rst_st_reg <= LS_START; rph_reg <= 4'h0;
                end
                LS_START: if (mid) begin
                    rph_reg <= 4'h8;
                    rst_st_reg <= rxd ? LS_IDLE : LS_DATA;
                    rbit_reg <= 4'h0; rpar_reg <= par_odd;
                end
                LS_DATA: if (mid) begin
                    rsh_reg <= par_on ? {1'b0, rxd, rsh_reg[6:1]} : {rxd, rsh_reg[7:1]};
                    rpar_reg <= rpar_reg ^ rxd;
                    rbit_reg <= rbit_reg + 4'h1;
                    if (rbit_reg == nbits - 4'h1) rst_st_reg <= par_on ? LS_PAR : LS_STOP;
                end
                LS_PAR: if (mid) begin
                    rx_perr_reg <= rpar_reg ^ rxd;
                    rst_st_reg <= LS_STOP;
                end
                default: if (mid) begin
                    // Accept at the first stop bit so the next start is never missed.
                    rx_stb_reg <= rxd;
                    rx_chr_reg <= rsh_reg;
                    rst_st_reg <= LS_IDLE;
                    if (!par_on) rx_perr_reg <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive buffer and Ctrl-C handling.
    logic [`FIFO_AW:0] level;
    wire is_ctrlc  = rx_stb_reg && rx_chr_reg == `CHAR_CTRLC;
    // Ctrl-C is honoured even with DTR false, so a deadlock can be broken.
    wire rx_accept = rx_stb_reg && !is_ctrlc;
    wire is_nl     = rx_accept && rx_chr_reg == `CHAR_NL;
    char_fifo #(.DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_fifo (
        .clk     (clk),
        .rst     (rst),
        .flush   (is_ctrlc),
        .wr_en   (rx_accept),
        .wr_data (rx_chr_reg),
        .rd_en   (cmd_pop),
        .rd_data (cmd_data),
        .level   (level)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter and flow control.
    line_st_t    tst_reg;
    logic [3:0]  tph_reg;
    logic [3:0]  tbit_reg;
    logic [7:0]  tsh_reg;
    logic        tpar_reg;
    logic        tlast_reg;
    logic        full_reg;
    logic        talk_reg;
    logic        nl_seen_reg;
    logic        held_reg;
    wire         tend = tick_reg && tph_reg == 4'hf;
    wire         take = tst_reg == LS_IDLE && rsp_valid && !rsp_ready && !is_ctrlc;
    wire         tx_done = tend && tst_reg == LS_STOP && tbit_reg == 4'(`STOP_BITS - 1);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tst_reg <= LS_IDLE; tph_reg <= 4'h0; tbit_reg <= 4'h0; tsh_reg <= 8'h0;
            tpar_reg <= 1'b0; tlast_reg <= 1'b0; txd <= 1'b1; rsp_ready <= 1'b0;
            held_reg <= 1'b0;
        end else begin
            rsp_ready <= 1'b0;
            if (tick_reg) tph_reg <= tph_reg + 4'h1;
            held_reg <= rsp_valid && !dsr && tst_reg == LS_IDLE;
            if (is_ctrlc) begin
                tst_reg <= LS_IDLE; txd <= 1'b1;
            end else case (tst_reg)
                LS_IDLE: if (take && dsr) begin
                    rsp_ready <= 1'b1; tsh_reg <= rsp_data; tlast_reg <= rsp_last;
                    tst_reg <= LS_START; tph_reg <= 4'h0; txd <= 1'b0;
                    tbit_reg <= 4'h0; tpar_reg <= par_odd;
                end
                LS_START: if (tend) begin
                    tst_reg <= LS_DATA; txd <= tsh_reg[0];
                end
                LS_DATA: if (tend) begin
                    tpar_reg <= tpar_reg ^ tsh_reg[0];
                    tsh_reg <= {1'b0, tsh_reg[7:1]};
                    tbit_reg <= tbit_reg + 4'h1;
                    if (tbit_reg == nbits - 4'h1) begin
                        tst_reg <= par_on ? LS_PAR : LS_STOP;
                        txd <= par_on ? tpar_reg ^ tsh_reg[0] : 1'b1;
                        tbit_reg <= 4'h0;
                    end else txd <= tsh_reg[1];
                end
                LS_PAR: if (tend) begin
                    tst_reg <= LS_STOP; txd <= 1'b1;
                end
                default: if (tend) begin
                    tbit_reg <= tbit_reg + 4'h1;
                    if (tx_done) tst_reg <= LS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            full_reg <= 1'b0; talk_reg <= 1'b0; nl_seen_reg <= 1'b0;
            dtr <= 1'b0; cmd_avail <= 1'b0; dev_clear <= 1'b0; parity_err <= 1'b0;
        end else begin
            dev_clear  <= is_ctrlc;
            parity_err <= rx_stb_reg && rx_perr_reg && par_on;
            cmd_avail  <= level != '0;
            if (level >= (`FIFO_AW+1)'(`FULL_LEVEL)) full_reg <= 1'b1;
            else if (level <= (`FIFO_AW+1)'(`RESUME_LEVEL)) full_reg <= 1'b0;
            // A newline landing as the last response bit ends must survive, so setting wins.
            if (is_nl) nl_seen_reg <= 1'b1;
            else if (is_ctrlc || (tx_done && tlast_reg)) nl_seen_reg <= 1'b0;
            talk_reg <= !is_ctrlc && resp_pend && (nl_seen_reg || is_nl);
            dtr <= !full_reg && !talk_reg && !held_reg && !is_ctrlc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    dtr_full_a: assert property (@(posedge clk) disable iff (rst)
        full_reg |=> !dtr) else $error("DTR true while buffer full.");
    dtr_held_a: assert property (@(posedge clk) disable iff (rst)
        held_reg |=> !dtr) else $error("DTR true while output held.");
    dtr_talk_a: assert property (@(posedge clk) disable iff (rst)
        talk_reg |=> !dtr) else $error("DTR true during response.");
    dtr_back_a: assert property (@(posedge clk) disable iff (rst)
        !full_reg && !talk_reg && !held_reg && !is_ctrlc |=> dtr)
        else $error("DTR not restored.");
    dsr_gate_a: assert property (@(posedge clk) disable iff (rst)
        rsp_ready |-> $past(dsr)) else $error("Sent with DSR false.");
    clear_flush_a: assert property (@(posedge clk) disable iff (rst)
        is_ctrlc |=> level == '0 && tst_reg == LS_IDLE) else $error("Ctrl-C did not flush.");
    frame_stop_a: assert property (@(posedge clk) disable iff (rst)
        tst_reg == LS_STOP |-> txd) else $error("Stop bit not high.");
    sequence take_s;
        tst_reg == LS_IDLE && take && dsr;
    endsequence
    sequence launch_s;
        rsp_ready && !txd ##1 !rsp_ready;
    endsequence
    tx_start_a: assert property (@(posedge clk) disable iff (rst)
        take_s |=> launch_s) else $error("Start bit not launched.");
    accept_rx_a: assert property (@(posedge clk) disable iff (rst)
        rx_accept && level < (`FIFO_AW+1)'(`FIFO_DEPTH) |=> level == $past(level) + (`FIFO_AW+1)'(1) - (`FIFO_AW+1)'($past(cmd_pop) && $past(level) != '0))
        else $error("Character lost.");
endmodule

// ===== verif/host_model.sv
// Host terminal model on the far side of a null-modem serial link.
`timescale 1ns/1ps
module host_model
    import serial_pkg::*;
#(
    parameter int CLK_HZ = 307200
) (
    input  wire logic      clk,  // System clock.
    input  wire line_cfg_t cfg,  // Line settings, same as the device.
    input  wire logic      dtr,  // Device ready for characters.
    input  wire logic      txd,  // Device transmit line.
    output logic           rxd   // Device receive line.
);
    logic [7:0] got_q[$];
    int         stop_errs = 0;
    initial rxd = 1'b1;
    // Bit time follows the same rate table as the device, or nothing decodes.
    function automatic int bit_len();
        return 16 * (CLK_HZ / 16 / (300 << ((cfg.baud_sel > 3'h5) ? 5 : cfg.baud_sel)));
    endfunction
    task automatic put_bit(input logic b);
        rxd <= b;
        repeat (bit_len()) @(posedge clk);
    endtask
    task automatic send_char(input logic [7:0] d, input logic wait_dtr, input logic bad_par);
        logic p;
        p = ^d[6:0] ^ (cfg.parity == PAR_ODD) ^ bad_par;
        while (wait_dtr && dtr !== 1'b1) @(posedge clk);
        put_bit(1'b0);
        for (int i = 0; i < ((cfg.parity == PAR_NONE) ? 8 : 7); i++) put_bit(d[i]);
        if (cfg.parity != PAR_NONE) put_bit(p);
        put_bit(1'b1);
        put_bit(1'b1);
    endtask
    initial begin
        logic [7:0] c;
        forever begin
            @(negedge txd);
            repeat (bit_len() / 2) @(posedge clk);
            c = 8'h00;
            for (int i = 0; i < ((cfg.parity == PAR_NONE) ? 8 : 7); i++) begin
                repeat (bit_len()) @(posedge clk);
                c[i] = txd;
            end
            if (cfg.parity != PAR_NONE) repeat (bit_len()) @(posedge clk);
            for (int i = 0; i < 2; i++) begin
                repeat (bit_len()) @(posedge clk);
                if (txd !== 1'b1) stop_errs++;
            end
            got_q.push_back(c);
        end
    end
endmodule

// ===== verif/rs232_dtr_dsr_flow_control_bench.sv
// Self-checking bench for the serial port with DTR/DSR flow control.
`timescale 1ns/1ps
module rs232_dtr_dsr_flow_control_bench;
    import serial_pkg::*;
    localparam int CLK_HZ = 16 * 9600 * 2;
    logic       clk, rst, rxd, dsr, txd, dtr, cmd_pop, cmd_avail, resp_pend;
    logic       rsp_valid, rsp_last, rsp_ready, dev_clear, parity_err;
    logic [7:0] cmd_data, rsp_data, c;
    line_cfg_t  cfg;
    logic [7:0] exp_q[$];
    logic [31:0] seed = 32'h033c54f3;
    int         err_count = 0, n_checks = 0, clr_seen = 0, perr_seen = 0;
    serial_port #(.CLK_HZ(CLK_HZ)) i_dut (.clk(clk), .rst(rst), .cfg(cfg), .rxd(rxd), .dsr(dsr), .txd(txd),
        .dtr(dtr), .cmd_pop(cmd_pop), .cmd_data(cmd_data), .cmd_avail(cmd_avail), .resp_pend(resp_pend),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_ready(rsp_ready),
        .dev_clear(dev_clear), .parity_err(parity_err));
    host_model #(.CLK_HZ(CLK_HZ)) h (.clk(clk), .cfg(cfg), .dtr(dtr), .txd(txd), .rxd(rxd));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Newline and Ctrl-C are control characters, so random payload avoids them in seven-bit mode too.
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return (seed[6:0] == 7'h03 || seed[6:0] == 7'h0a) ? seed[7:0] ^ 8'h10 : seed[7:0];
    endfunction
    task automatic pop(output logic [7:0] d);
        @(posedge clk);
        cmd_pop <= 1'b1;
        @(posedge clk);
        cmd_pop <= 1'b0;
        @(posedge clk);
        d = cmd_data;
    endtask
    task automatic respond(input logic [7:0] d, input logic last);
        int t;
        @(posedge clk);
        rsp_valid <= 1'b1;
        rsp_data <= d;
        rsp_last <= last;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (rsp_ready !== 1'b1 && t < 3000);
        rsp_valid <= 1'b0;
        check(t < 3000, 1'b1);
    endtask
    always @(posedge clk) begin
        if (dev_clear === 1'b1) clr_seen++;
        if (parity_err === 1'b1) perr_seen++;
    end
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        // The whole run needs about 65000 cycles, most of it in the 105-character fill at 9600 baud.
        repeat (80000) @(posedge clk);
        err_count++;
        end_sim();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, dsr, cmd_pop, resp_pend, rsp_valid, rsp_last, rsp_data} = {6'b110000, 8'h00};
        cfg = '{baud_sel: 3'h5, parity: PAR_NONE};
        repeat (5) @(posedge clk);
        check(dtr, 1'b0);
        check(txd, 1'b1);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        check(dtr, 1'b1);
        // Fill to the stop level, then overrun by five as a slow host may.
        for (int i = 0; i < 105; i++) begin
            c = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : rnd();
            exp_q.push_back(c);
            if (i < 100) check(dtr, 1'b1);
            h.send_char(c, i < 100, 1'b0);
            if (i == 99) check(dtr, 1'b0);
        end
        for (int i = 0; i < 105; i++) begin
            pop(c);
            check(c, exp_q.pop_front());
            if (i == 23) check(dtr, 1'b0);
            if (i == 24) begin
                repeat (3) @(posedge clk);
                check(dtr, 1'b1);
            end
        end
        repeat (2) @(posedge clk);
        check(cmd_avail, 1'b0);
        // Query answered while the host first withholds DSR.
        resp_pend <= 1'b1;
        h.send_char(8'h3f, 1'b1, 1'b0);
        h.send_char(8'h0a, 1'b1, 1'b0);
        check(dtr, 1'b0);
        pop(c);
        pop(c);
        check(dtr, 1'b0);
        dsr <= 1'b0;
        for (int k = 0; k < 3; k++) exp_q.push_back(rnd());
        fork
            respond(exp_q[0], 1'b0);
            begin
                repeat (200) @(posedge clk);
                check(rsp_ready, 1'b0);
                check(dtr, 1'b0);
                check(txd, 1'b1);
                dsr <= 1'b1;
            end
        join
        respond(exp_q[1], 1'b0);
        respond(exp_q[2], 1'b1);
        resp_pend <= 1'b0;
        repeat (400) @(posedge clk);
        check(dtr, 1'b1);
        check(h.got_q.size(), 8'h03);
        while (h.got_q.size() > 0) check(h.got_q.pop_front(), exp_q.pop_front());
        check(h.stop_errs, 8'h00);
        // A stalled response is broken up by Ctrl-C.
        resp_pend <= 1'b1;
        h.send_char(8'h51, 1'b1, 1'b0);
        h.send_char(8'h0a, 1'b1, 1'b0);
        dsr <= 1'b0;
        rsp_valid <= 1'b1;
        rsp_last <= 1'b1;
        h.send_char(8'h03, 1'b0, 1'b0);
        repeat (4) @(posedge clk);
        check(clr_seen, 8'h01);
        check(cmd_avail, 1'b0);
        rsp_valid <= 1'b0;
        resp_pend <= 1'b0;
        dsr <= 1'b1;
        repeat (400) @(posedge clk);
        check(h.got_q.size(), 8'h00);
        check(dtr, 1'b1);
        // Every rate and parity mode without flow control, with one bad parity character.
        exp_q.delete();
        for (int s = 0; s < 6; s++) begin
            cfg <= '{baud_sel: s[2:0], parity: parity_t'(s % 3)};
            @(posedge clk);
            c = rnd();
            exp_q.push_back((s % 3 == 0) ? c : {1'b0, c[6:0]});
            h.send_char(c, 1'b0, 1'b0);
            pop(c);
            check(c, exp_q.pop_front());
        end
        h.send_char(8'h35, 1'b1, 1'b1);
        repeat (8) @(posedge clk);
        check(perr_seen, 8'h01);
        end_sim();
    end
endmodule
